// file: rtl/spi_port_consts.svh
// Bit positions, reset values and counts of the serial master port.
// Assumes nothing; included by the package and the port module.
`ifndef SPI_PORT_CONSTS_SVH
`define SPI_PORT_CONSTS_SVH

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTL_RATE2      7
`define CTL_EN         6
`define CTL_MASTER_SELECT_BIT       4
`define CTL_CLOCK_POLARITY       3
`define CTL_CLOCK_PHASE       2
`define CTL_RATE1      1
`define CTL_RATE0      0
`define CTL_RESET      8'h10

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define STA_TC         7
`define STA_WRITE_COLLISION_FLAG       6
`define STA_MODE_FAULT_FLAG       4

// ----------------------------------------------------------------
// Sizes and counts
// ----------------------------------------------------------------
`define BYTE_W         8
`define RATE_EXT       3'h7
`define LAST_EDGE      5'h0F
`define DIV_W          7
`define RX_DEPTH       16
`define XFER_MAX       11'h400

`endif

// file: rtl/spi_port_pkg.sv
// Types shared by the serial master port.
// Assumes the constants header sits beside it.
`include "spi_port_consts.svh"

package spi_port_pkg;

  typedef enum logic [0:0] {S_IDLE, S_XFER} xfer_state_t;

  typedef struct packed {
    logic [`BYTE_W-1:0] ctrl;
    logic               tc;
    logic               write_collision_flag;
    logic               mode_fault_flag;
    logic               tc_arm;
    logic               write_collision_flag_arm;
    logic               mode_fault_flag_arm;
    xfer_state_t        state;
    logic [4:0]         edge_cnt;
    logic [`DIV_W-1:0]  div_cnt;
    logic               sck;
    logic               mosi;
    logic [`BYTE_W-1:0] tx;
    logic [`BYTE_W-1:0] rx;
    logic [`BYTE_W-1:0] rdata;
    logic               push;
  } port_state_t;

endpackage

// file: rtl/byte_stream_if.sv
// Valid/ready byte stream between the shifter and the receive FIFO.
// Assumes both ends share one clock.
`timescale 1ns/1ps

interface byte_stream_if #(parameter int W = 8) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

// file: rtl/rx_fifo.sv
// Receive FIFO with width and depth as parameters.
// Assumes a synchronous active-low reset; DEPTH a power of two.
`timescale 1ns/1ps

module rx_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic     clk,
  input  wire logic     rst_n,
  byte_stream_if.sink   wr,
  byte_stream_if.source rd
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   count;
  } fifo_state_t;

  fifo_state_t  st_r;
  fifo_state_t  st_nxt;
  logic [W-1:0] mem [DEPTH];
  logic         do_wr;
  logic         do_rd;

  assign wr.ready = (st_r.count != (AW+1)'(DEPTH));
  assign rd.valid = (st_r.count != '0);
  assign rd.data  = mem[st_r.rp];
  assign do_wr    = wr.valid && wr.ready;
  assign do_rd    = rd.valid && rd.ready;

  always_comb begin
    st_nxt = st_r;
    if (do_wr) begin
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (do_rd) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    case ({do_wr, do_rd})
      2'b10:   st_nxt.count = st_r.count + 1'b1;
      2'b01:   st_nxt.count = st_r.count - 1'b1;
      default: st_nxt.count = st_r.count;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[st_r.wp] <= wr.data;
    end
  end

  a_fifo_no_overfill: assert property (
    @(posedge clk) disable iff (!rst_n)
    !wr.ready |=> st_r.count == $past(st_r.count) - ($past(do_rd) ? 1 : 0))
    else $error("fifo count moved while full");
endmodule

// file: rtl/spi_port.sv
// Serial master port: control, status and data strobes on one side,
// clock, data out, data in and select on the other.
// Assumes all inputs synchronous to MCLK; BRG_TICK one cycle per edge.
`timescale 1ns/1ps
`include "spi_port_consts.svh"

module spi_port (
  input  wire logic       MCLK,
  input  wire logic       RST_N,
  input  wire logic       CTRL_WR,
  input  wire logic [7:0] CTRL_WDATA,
  input  wire logic       STAT_RD,
  input  wire logic       DATA_WR,
  input  wire logic [7:0] DATA_WDATA,
  input  wire logic       DATA_RD,
  input  wire logic       BRG_TICK,
  input  wire logic       MISO,
  input  wire logic       SS_N,
  output logic [7:0]      CTRL_Q,
  output logic [7:0]      STAT_Q,
  output logic [7:0]      DATA_Q,
  output logic            SCK,
  output logic            MOSI,
  output logic            TX_IRQ,
  output logic            ERR_IRQ
);
  import spi_port_pkg::*;

  port_state_t        st_r;
  port_state_t        st_nxt;
  logic [2:0]         rate;
  logic [7:0]         one_hot;
  logic [`DIV_W-1:0]  half_last;
  logic               tick;
  logic               en;
  logic               master_select_bit;
  logic               clock_polarity;
  logic               clock_phase;
  logic               fault;
  logic               start;
  logic               leading;
  logic               sample_now;
  logic               drive_now;

  byte_stream_if #(.W(`BYTE_W)) push_if ();
  byte_stream_if #(.W(`BYTE_W)) pop_if ();

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  // Full buffer holds off the next start rather than losing a byte.
  rx_fifo #(.W(`BYTE_W), .DEPTH(`RX_DEPTH)) u_rx_fifo (
    .clk   (MCLK),
    .rst_n (RST_N),
    .wr    (push_if.sink),
    .rd    (pop_if.source)
  );

  assign push_if.valid = st_r.push;
  assign push_if.data  = st_r.rx;
  assign pop_if.ready  = DATA_RD;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign en    = st_r.ctrl[`CTL_EN];
  assign master_select_bit  = st_r.ctrl[`CTL_MASTER_SELECT_BIT];
  assign clock_polarity  = st_r.ctrl[`CTL_CLOCK_POLARITY];
  assign clock_phase  = st_r.ctrl[`CTL_CLOCK_PHASE];
  assign rate  = {st_r.ctrl[`CTL_RATE2], st_r.ctrl[`CTL_RATE1],
                  st_r.ctrl[`CTL_RATE0]};
  assign fault = en && master_select_bit && !SS_N;

  // Rates below 7: half period of 2^rate cycles gives SCK = MCLK / 2^(rate+1)
  assign one_hot   = 8'h01 << rate;
  assign half_last = one_hot[`DIV_W-1:0] - 7'h01;
  assign tick      = (rate == `RATE_EXT) ? BRG_TICK
                   : (st_r.div_cnt == half_last);

  assign leading    = !st_r.edge_cnt[0];
  assign sample_now = clock_phase ? !leading : leading;
  assign drive_now  = clock_phase ? leading
                    : (!leading && st_r.edge_cnt != `LAST_EDGE);

  // Port inert unless both enabled and master
  assign start = DATA_WR && st_r.state == S_IDLE && en && master_select_bit
                 && push_if.ready && !fault;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt      = st_r;
    st_nxt.push = 1'b0;

    if (CTRL_WR) begin
      st_nxt.ctrl = CTRL_WDATA;
      if (st_r.mode_fault_flag_arm) begin
        st_nxt.mode_fault_flag     = 1'b0;
        st_nxt.mode_fault_flag_arm = 1'b0;
      end
    end

    if (STAT_RD) begin
      st_nxt.tc_arm   = st_r.tc;
      st_nxt.write_collision_flag_arm = st_r.write_collision_flag;
      st_nxt.mode_fault_flag_arm = st_r.mode_fault_flag;
    end

    if ((DATA_WR || DATA_RD) && st_r.tc_arm) begin
      st_nxt.tc     = 1'b0;
      st_nxt.tc_arm = 1'b0;
    end
    if ((DATA_WR || DATA_RD) && st_r.write_collision_flag_arm) begin
      st_nxt.write_collision_flag     = 1'b0;
      st_nxt.write_collision_flag_arm = 1'b0;
    end

    if (DATA_RD && pop_if.valid) begin
      st_nxt.rdata = pop_if.data;
    end

    case (st_r.state)
      S_IDLE: begin
        st_nxt.sck = clock_polarity;
        if (start) begin
          st_nxt.state    = S_XFER;
          st_nxt.edge_cnt = '0;
          st_nxt.div_cnt  = '0;
          st_nxt.tx       = DATA_WDATA;
          if (!clock_phase) begin
            // MSB must be on the wire before the first edge
            st_nxt.mosi = DATA_WDATA[7];
            st_nxt.tx   = {DATA_WDATA[6:0], 1'b0};
          end
        end
      end
      S_XFER: begin
        // A collision only flags; the shifter is left untouched
        if (DATA_WR) begin
          st_nxt.write_collision_flag = 1'b1;
        end
        st_nxt.div_cnt = tick ? '0 : st_r.div_cnt + 7'h01;
        if (tick) begin
          st_nxt.sck      = !st_r.sck;
          st_nxt.edge_cnt = st_r.edge_cnt + 5'h01;
          if (sample_now) begin
            st_nxt.rx = {st_r.rx[6:0], MISO};
          end
          if (drive_now) begin
            st_nxt.mosi = st_r.tx[7];
            st_nxt.tx   = {st_r.tx[6:0], 1'b0};
          end
          if (st_r.edge_cnt == `LAST_EDGE) begin
            st_nxt.state = S_IDLE;
            st_nxt.push  = 1'b1;
            st_nxt.tc    = 1'b1;
          end
        end
      end
      default: begin
        st_nxt.state = S_IDLE;
      end
    endcase

    // Fault overrides any control write in the same cycle
    if (fault) begin
      st_nxt.mode_fault_flag           = 1'b1;
      st_nxt.ctrl[`CTL_EN]   = 1'b0;
      st_nxt.ctrl[`CTL_MASTER_SELECT_BIT] = 1'b0;
      st_nxt.state          = S_IDLE;
      st_nxt.sck            = clock_polarity;
    end

    // Dropping enable or master mid-byte abandons it without a flag
    if (!en || !master_select_bit) begin
      st_nxt.state = S_IDLE;
      st_nxt.sck   = clock_polarity;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      st_r      <= '0;
      st_r.ctrl <= `CTL_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign CTRL_Q  = st_r.ctrl;
  assign STAT_Q  = {st_r.tc, st_r.write_collision_flag, 1'b0, st_r.mode_fault_flag, 4'h0};
  assign DATA_Q  = st_r.rdata;
  assign SCK     = st_r.sck;
  assign MOSI    = st_r.mosi;
  assign TX_IRQ  = st_r.tc;
  assign ERR_IRQ = st_r.mode_fault_flag;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [4:0]  sck_toggles;
  logic [10:0] busy_cnt;

  // Saturates so a stalled external rate cannot wrap it
  always_ff @(posedge MCLK) begin
    if (!RST_N || start) begin
      busy_cnt <= '0;
    end else if (st_r.state == S_XFER && busy_cnt != 11'h7FF) begin
      busy_cnt <= busy_cnt + 11'h001;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N || start) begin
      sck_toggles <= '0;
    end else if (st_r.state == S_XFER && SCK != st_nxt.sck) begin
      sck_toggles <= sck_toggles + 5'h01;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  a_eight_clocks: assert property (
    $rose(st_r.push) |-> sck_toggles == 5'h10 && SCK == clock_polarity)
    else $error("byte did not take sixteen sck edges");

  a_sck_idle_level: assert property (
    st_r.state == S_IDLE ##1 st_r.state == S_IDLE
      |-> SCK == $past(clock_polarity))
    else $error("sck not at idle level");

  a_msb_lead: assert property (
    start && !clock_phase |=> MOSI == $past(DATA_WDATA[7]))
    else $error("msb not driven before first edge");

  a_mode_fault: assert property (
    fault |=> STAT_Q[`STA_MODE_FAULT_FLAG] && ERR_IRQ && !CTRL_Q[`CTL_EN]
      && !CTRL_Q[`CTL_MASTER_SELECT_BIT] && st_r.state == S_IDLE)
    else $error("mode fault not handled");

  a_fault_clear: assert property (
    st_r.mode_fault_flag_arm && CTRL_WR && !fault
      |=> !ERR_IRQ)
    else $error("fault flag not cleared");

  a_write_collision_flag_set: assert property (
    DATA_WR && st_r.state == S_XFER && !fault
      |=> STAT_Q[`STA_WRITE_COLLISION_FLAG] && st_r.state == S_XFER
          || $rose(st_r.push))
    else $error("collision lost or transfer broken");

  a_write_collision_flag_quiet: assert property (
    DATA_WR && st_r.state == S_XFER |=> $stable(ERR_IRQ) || $rose(ERR_IRQ)
      && $past(fault))
    else $error("collision touched the error request");

  a_tc_clear: assert property (
    st_r.tc_arm && (DATA_RD || DATA_WR)
      && !(st_r.state == S_XFER && tick && st_r.edge_cnt == `LAST_EDGE)
      |=> !TX_IRQ)
    else $error("complete flag not cleared");

  a_start_xfer: assert property (
    start |=> st_r.state == S_XFER)
    else $error("transfer did not start");

  a_xfer_bounded: assert property (
    st_r.state == S_XFER && rate != `RATE_EXT |-> busy_cnt < `XFER_MAX)
    else $error("transfer outlasted the slowest rate");

  a_master_only: assert property (
    !master_select_bit || !en |=> st_r.state == S_IDLE || CTRL_WR)
    else $error("transfer while not enabled master");
endmodule

// file: bench/spi_slave_model.sv
// Behavioural slave on the far side of the serial master port.
// Assumes the bench gives it the same polarity and phase as the port.
`timescale 1ns/1ps

module spi_slave_model (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic       clock_polarity,
  input  wire logic       clock_phase,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte
);
  logic [7:0] sh;
  logic       out_r;
  logic       fresh;

  initial begin
    sh      = 8'h00;
    out_r   = 1'b0;
    fresh   = 1'b0;
    rx_byte = 8'h00;
  end

  // Deselected: inverse of last bit, so a stale sample shows up
  assign miso = sel_n ? ~out_r : out_r;

  // Phase zero: first bit out before the first edge
  always @(negedge sel_n) begin
    sh    = tx_byte;
    fresh = clock_phase;
    if (!clock_phase)
      out_r = sh[7];
  end

  // Leading edge leaves the idle level; phase picks sample or shift
  always @(sck) begin
    if (!sel_n) begin
      if ((sck != clock_polarity) ^ clock_phase)
        rx_byte = {rx_byte[6:0], mosi};
      else begin
        if (!fresh)
          sh = sh << 1;
        fresh = 1'b0;
        out_r = sh[7];
      end
    end
  end
endmodule

// file: bench/tb_top.sv
// Bench for the serial master port: strobe tasks, transfers, faults.
// Assumes the slave model and the design files are compiled first.
`timescale 1ns/1ps

`define CHK(nm, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("wrong value %s exp %0h got %0h", nm, exp, got); \
    end \
  end

module tb_top;
  logic       mclk, rst_n, ctrl_wr, stat_rd, data_wr, data_rd;
  logic       brg_tick, ss_n, sel_n, clock_polarity, clock_phase;
  logic [7:0] ctrl_wdata, data_wdata, slv_tx;
  logic [1:0] tick_c;
  wire  [7:0] ctrl_q, stat_q, data_q, slv_rx;
  wire        sck, mosi, tx_irq, err_irq, miso;
  int         fails, total_checks, idle_edges;
  logic [7:0] cv;

  spi_port dut_u (.MCLK(mclk), .RST_N(rst_n), .CTRL_WR(ctrl_wr),
    .CTRL_WDATA(ctrl_wdata), .STAT_RD(stat_rd), .DATA_WR(data_wr),
    .DATA_WDATA(data_wdata), .DATA_RD(data_rd), .BRG_TICK(brg_tick),
    .MISO(miso), .SS_N(ss_n), .CTRL_Q(ctrl_q), .STAT_Q(stat_q),
    .DATA_Q(data_q), .SCK(sck), .MOSI(mosi), .TX_IRQ(tx_irq),
    .ERR_IRQ(err_irq));

  spi_slave_model slave_u (.sck(sck), .mosi(mosi), .sel_n(sel_n),
    .clock_polarity(clock_polarity), .clock_phase(clock_phase), .tx_byte(slv_tx), .miso(miso),
    .rx_byte(slv_rx));

  always #20 mclk = ~mclk;

  // External rate tick, one pulse every fourth cycle
  always @(posedge mclk) begin
    tick_c   <= tick_c + 2'h1;
    brg_tick <= (tick_c == 2'h3);
  end

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // k: 0 control write, 1 status read, 2 data write, 3 data read
  task automatic strobe(input int k, input logic [7:0] v);
    @(posedge mclk);
    ctrl_wdata <= v;
    data_wdata <= v;
    {ctrl_wr, stat_rd, data_wr, data_rd} <= 4'h8 >> k;
    @(posedge mclk);
    {ctrl_wr, stat_rd, data_wr, data_rd} <= 4'h0;
  endtask

  task automatic xfer(input logic [2:0] r, input logic coll,
                      input logic [7:0] tb, input logic [7:0] sb,
                      input logic rd);
    int   n;
    int   e;
    logic p;
    n = 0;
    e = 0;
    p = clock_polarity;
    @(posedge mclk) slv_tx <= sb;
    @(posedge mclk) sel_n <= 1'b0;
    strobe(1, 8'h00);
    strobe(2, tb);
    do begin
      @(posedge mclk);
      data_wr <= coll && n == 8;
      #1;
      n++;
      if (sck !== p)
        e++;
      p = sck;
    end while (tx_irq !== 1'b1 && n < 5000);
    `CHK("done", 1'b1, tx_irq)
    if (r != 3'h7) `CHK("cycles", 16 * (2 ** r), n)
    `CHK("edges", 16, e)
    `CHK("idle sck", clock_polarity, sck)
    `CHK("complete", 1'b1, stat_q[7])
    `CHK("collision", coll, stat_q[6])
    `CHK("err irq", 1'b0, err_irq)
    @(posedge mclk) sel_n <= 1'b1;
    #1 `CHK("slave rx", tb, slv_rx)
    if (rd) begin
      strobe(1, 8'h00);
      strobe(3, 8'h00);
      @(posedge mclk);
      #1 `CHK("rx byte", sb, data_q)
      `CHK("complete clr", 1'b0, stat_q[7])
      `CHK("collision clr", 1'b0, stat_q[6])
    end
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    wrap_up();
  end

  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    {ctrl_wr, stat_rd, data_wr, data_rd, brg_tick} = 5'h00;
    {clock_polarity, clock_phase, tick_c} = 4'h0;
    ss_n = 1'b1;
    sel_n = 1'b1;
    {ctrl_wdata, data_wdata, slv_tx} = 24'h000000;
    fails = 0;
    total_checks = 0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    #1 `CHK("ctrl reset", 8'h10, ctrl_q)
    `CHK("stat reset", 8'h00, stat_q)
    `CHK("sck reset", 1'b0, sck)
    // ------------------------------------------------------------
    // Every rate code and every polarity and phase pair
    // ------------------------------------------------------------
    for (int i = 0; i < 8; i++) begin
      strobe(0, 8'h10);
      @(posedge mclk) {clock_polarity, clock_phase} <= 2'(i);
      cv = {i[2], 3'h5, i[1], i[0], i[1], i[0]};
      strobe(0, cv);
      #1 `CHK("ctrl", cv, ctrl_q)
      xfer(3'(i), i == 3, 8'h81 ^ 8'(i), 8'h5A + 8'(i), 1'b1);
    end
    // ------------------------------------------------------------
    // Mode fault and its clearing sequence
    // ------------------------------------------------------------
    @(posedge mclk) ss_n <= 1'b0;
    @(posedge mclk) ss_n <= 1'b1;
    @(posedge mclk);
    #1 `CHK("fault", 1'b1, stat_q[4])
    `CHK("err irq", 1'b1, err_irq)
    `CHK("en master_select_bit", 2'h0, {ctrl_q[6], ctrl_q[4]})
    strobe(0, 8'h10);
    #1 `CHK("fault kept", 1'b1, stat_q[4])
    strobe(1, 8'h00);
    strobe(0, 8'h10);
    #1 `CHK("fault clr", 1'b0, stat_q[4])
    @(posedge mclk) {clock_polarity, clock_phase} <= 2'h0;
    strobe(0, 8'h50);
    // ------------------------------------------------------------
    // Fill the receive buffer, refuse a start, then drain it
    // ------------------------------------------------------------
    for (int k = 0; k < 16; k++)
      xfer(3'h0, 1'b0, 8'(k), 8'hE0 + 8'(k), 1'b0);
    strobe(1, 8'h00);
    strobe(2, 8'h77);
    idle_edges = 0;
    repeat (40) begin
      @(posedge mclk);
      #1 if (sck !== 1'b0)
        idle_edges++;
    end
    `CHK("full start", 0, idle_edges)
    for (int k = 0; k < 16; k++) begin
      strobe(3, 8'h00);
      @(posedge mclk);
      #1 `CHK("fifo", 8'hE0 + 8'(k), data_q)
    end
    strobe(3, 8'h00);
    @(posedge mclk);
    #1 `CHK("empty pop", 8'hEF, data_q)
    wrap_up();
  end
endmodule
